// ---- design/can_win_pkg.sv ----
// constants and carrier types for the message object mask and data window
// assumes an 8-bit special function register bus on the system clock
package can_win_pkg;

  localparam logic [7:0] ADDR_MSG = 8'ha3;
  localparam logic [7:0] ADDR_MASK1 = 8'hc4;
  localparam logic [7:0] ADDR_MASK2 = 8'hc5;
  localparam logic [7:0] ADDR_MASK3 = 8'hc6;
  localparam logic [7:0] ADDR_MASK4 = 8'hc7;

  localparam int OBJ_N = 15;
  localparam int DATA_BYTES = 8;
  localparam int MEM_WORDS = OBJ_N * DATA_BYTES;
  localparam logic [3:0] OBJ_LAST = 4'he;
  localparam logic [2:0] IDX_RESET = 3'h0;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // bit positions inside the fourth mask byte
  localparam int RTR_MASK_BIT = 2;
  localparam int IDE_MASK_BIT = 0;
  // readable bits per byte, reserved bits read as zero
  localparam logic [7:0] STD_KEEP2 = 8'he0;
  localparam logic [7:0] STD_KEEP3 = 8'h00;
  localparam logic [7:0] STD_KEEP4 = 8'h05;
  localparam logic [7:0] EXT_KEEP4 = 8'hfd;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic check;
    logic [3:0] obj;
    logic ext_layout;
    logic [28:0] id;
    logic rtr;
    logic ide;
    logic [28:0] tag_id;
    logic tag_rtr;
    logic tag_ide;
  } rx_frame_t;

  typedef struct packed {
    logic [3:0] obj;
    logic [2:0] idx;
    logic load;
    logic ext_layout;
    logic auto_inc;
  } page_sel_t;

endpackage : can_win_pkg

// ---- design/can_msg_ram.sv ----
// byte store holding the eight data bytes of every message object
// assumes one write or one read per cycle; read data is registered
`timescale 1ns/1ps
`default_nettype none
module can_msg_ram (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic we,
  input wire logic re,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  import can_win_pkg::*;

  typedef struct packed {
    logic [MEM_WORDS-1:0][7:0] mem;
    logic [7:0] rdata;
  } ram_state_t;

  ram_state_t s_q;
  ram_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (we) begin
      s_d.mem[addr] = wdata;
    end
    if (re) begin
      s_d.rdata = s_q.mem[addr];
    end
  end

  // contents are cleared only so simulation starts known; software
  // must still load every byte before trusting it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

endmodule : can_msg_ram
`default_nettype wire

// ---- design/can_mask_window.sv ----
// acceptance masks and cyclic data window of the message objects
// assumes page selection, tag registers and protocol engine outside;
// all inputs come from logic on clk_sys, so nothing is synchronised
`timescale 1ns/1ps
`default_nettype none

module can_mask_window (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire can_win_pkg::sfr_req_t sfr,
  input wire can_win_pkg::page_sel_t page,
  input wire can_win_pkg::rx_frame_t rx,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic [2:0] data_index,
  output logic rx_hit,
  output logic rx_hit_valid
);
  import can_win_pkg::*;

  typedef struct packed {
    logic [OBJ_N-1:0][31:0] mask;
    logic [2:0] idx;
    logic rd_pend;
    logic rd_ext;
    logic [7:0] rd_addr;
    logic [3:0] rd_obj;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    logic hit_valid;
  } win_state_t;

  win_state_t s_q;
  win_state_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic obj_ok(input logic [3:0] obj);
    obj_ok = (obj <= OBJ_LAST);
  endfunction : obj_ok

  function automatic logic is_mask(input logic [7:0] a);
    is_mask = (a == ADDR_MASK1) || (a == ADDR_MASK2) ||
              (a == ADDR_MASK3) || (a == ADDR_MASK4);
  endfunction : is_mask

  // one mask byte as seen by software, reserved bits forced low
  function automatic logic [7:0] mask_view(input logic [31:0] m,
                                           input logic [7:0] a,
                                           input logic ext);
    logic [7:0] v;
    v = BYTE_RESET;
    case (a)
      ADDR_MASK1: v = m[31:24];
      ADDR_MASK2: v = ext ? m[23:16] : (m[23:16] & STD_KEEP2);
      ADDR_MASK3: v = ext ? m[15:8] : (m[15:8] & STD_KEEP3);
      ADDR_MASK4: v = ext ? (m[7:0] & EXT_KEEP4) : (m[7:0] & STD_KEEP4);
      default: v = BYTE_RESET;
    endcase
    return v;
  endfunction : mask_view

  // zero mask bit forces true, one bit demands received equals tag
  function automatic logic accept(input logic [31:0] m,
                                  input rx_frame_t f);
    logic [28:0] idm;
    logic idok;
    logic rtrok;
    logic ideok;
    idm = f.ext_layout ? m[31:3] : {18'h0, m[31:24], m[23:21]};
    idok = &(~idm | ~(f.id ^ f.tag_id));
    rtrok = !m[RTR_MASK_BIT] || (f.rtr == f.tag_rtr);
    ideok = !m[IDE_MASK_BIT] || (f.ide == f.tag_ide);
    return idok && rtrok && ideok;
  endfunction : accept

  ////////////////////////////////////////////////////////////////////////
  // data byte store

  logic win_wr;
  logic win_rd;
  logic any_rd;
  logic win_step;
  logic [7:0] mem_rdata;
  logic [6:0] mem_addr;

  assign any_rd = sfr.rd && !sfr.wr;
  assign win_wr = sfr.wr && (sfr.addr == ADDR_MSG) && obj_ok(page.obj);
  assign win_rd = any_rd && (sfr.addr == ADDR_MSG) && obj_ok(page.obj);
  assign win_step = win_wr || win_rd;
  // the page load wins over a step in the same cycle, but that access still uses the old index
  assign mem_addr = 7'(({3'h0, page.obj} << 3) + {4'h0, s_q.idx});

  can_msg_ram u_ram (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .we(win_wr),
    .re(win_rd),
    .addr(mem_addr),
    .wdata(sfr.wdata),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.hit_valid = 1'b0;
    // masks are stored whole; reserved bits are hidden on read and
    // skipped by the filter instead of being dropped on write
    if (sfr.wr && is_mask(sfr.addr) && obj_ok(page.obj)) begin
      case (sfr.addr)
        ADDR_MASK1: s_d.mask[page.obj][31:24] = sfr.wdata;
        ADDR_MASK2: s_d.mask[page.obj][23:16] = sfr.wdata;
        ADDR_MASK3: s_d.mask[page.obj][15:8] = sfr.wdata;
        ADDR_MASK4: s_d.mask[page.obj][7:0] = sfr.wdata;
        default: s_d.mask[page.obj] = s_q.mask[page.obj];
      endcase
    end
    if (page.load) begin
      s_d.idx = page.idx;
    end else if (win_step && page.auto_inc) begin
      s_d.idx = 3'(s_q.idx + 3'h1);
    end
    s_d.rd_pend = any_rd && obj_ok(page.obj) &&
                  (is_mask(sfr.addr) || sfr.addr == ADDR_MSG);
    if (any_rd) begin
      s_d.rd_addr = sfr.addr;
      s_d.rd_ext = page.ext_layout;
      s_d.rd_obj = page.obj;
    end
    if (s_q.rd_pend) begin
      s_d.rvalid = 1'b1;
      if (s_q.rd_addr == ADDR_MSG) begin
        s_d.rdata = mem_rdata;
      end else begin
        s_d.rdata = mask_view(s_q.mask[s_q.rd_obj], s_q.rd_addr,
                              s_q.rd_ext);
      end
    end
    // only a receive check on a valid object updates the filter result
    if (rx.check && obj_ok(rx.obj)) begin
      s_d.hit_valid = 1'b1;
      s_d.hit = accept(s_q.mask[rx.obj], rx);
    end
  end

  // masks and bytes hold zero after reset only for a known simulation
  // start; nothing promises it, so software loads them first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign sfr_rvalid = s_q.rvalid;
  assign data_index = s_q.idx;
  assign rx_hit = s_q.hit;
  assign rx_hit_valid = s_q.hit_valid;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic [31:0] sel_mask;
  assign sel_mask = obj_ok(rx.obj) ? s_q.mask[rx.obj] : MASK_RESET;

  sequence mask1_write;
    sfr.wr && sfr.addr == ADDR_MASK1 && obj_ok(page.obj) && !page.load;
  endsequence

  sequence same_obj_read;
    any_rd && sfr.addr == ADDR_MASK1 && $stable(page.obj);
  endsequence

  sequence win_read;
    any_rd && sfr.addr == ADDR_MSG && obj_ok(page.obj);
  endsequence

  sequence mask_read;
    any_rd && is_mask(sfr.addr) && obj_ok(page.obj);
  endsequence

  // index must not move between the write and the read behind it
  sequence win_write_hold;
    sfr.wr && sfr.addr == ADDR_MSG && obj_ok(page.obj) &&
      !page.auto_inc && !page.load;
  endsequence

  sequence win_read_same;
    any_rd && sfr.addr == ADDR_MSG && $stable(page.obj) && !page.load;
  endsequence

  idx_wrap_a: assert property (
    win_step && page.auto_inc && !page.load |=>
      data_index == 3'($past(data_index) + 3'h1))
    else $error("data index did not advance by one");

  idx_hold_a: assert property (
    win_step && !page.auto_inc && !page.load |=> $stable(data_index))
    else $error("data index moved without auto-increment");

  // back to back reads are legal, so only the answer edge is pinned
  read_lat_a: assert property (
    win_read |-> ##2 sfr_rvalid)
    else $error("window read not answered two cycles later");

  hit_rx_only_a: assert property (
    !rx.check |=> !rx_hit_valid)
    else $error("filter result without a receive check");

  open_mask_a: assert property (
    rx.check && obj_ok(rx.obj) && sel_mask == MASK_RESET |=>
      rx_hit_valid && rx_hit)
    else $error("all-open mask failed to accept");

  rtr_gate_a: assert property (
    rx.check && obj_ok(rx.obj) && sel_mask[RTR_MASK_BIT] &&
      rx.rtr != rx.tag_rtr |=> !rx_hit)
    else $error("remote bit mismatch accepted with mask set");

  // the read was taken two edges ago; a following read has already
  // moved the latched address on, so look back at the bus itself
  std_rsvd_a: assert property (
    sfr_rvalid && !$past(page.ext_layout, 2) &&
      $past(sfr.addr, 2) != ADDR_MSG |->
      (sfr_rdata & ~mask_view(32'hffff_ffff, $past(sfr.addr, 2), 1'b0)) ==
        BYTE_RESET)
    else $error("reserved standard bits read as one");

  mask_back_a: assert property (
    mask1_write ##1 same_obj_read |-> ##2
      sfr_rdata == $past(sfr.wdata, 3))
    else $error("first mask byte did not read back");

  win_back_a: assert property (
    win_write_hold ##1 win_read_same |-> ##2
      sfr_rdata == $past(sfr.wdata, 3))
    else $error("window byte did not read back");

  mask_lat_a: assert property (
    mask_read |-> ##2 sfr_rvalid)
    else $error("mask read not answered two cycles later");

  // an answer with no read behind it would shift every later byte
  rvalid_src_a: assert property (
    sfr_rvalid |-> $past(any_rd, 2))
    else $error("read answer without a read");

  no_obj_read_a: assert property (
    any_rd && !obj_ok(page.obj) |-> ##2 !sfr_rvalid)
    else $error("read answered with no object selected");

  idx_load_a: assert property (
    page.load |=> data_index == $past(page.idx))
    else $error("data index not loaded from the page");

  ////////////////////////////////////////////////////////////////////////
  // filter checks

  hit_answer_a: assert property (
    rx.check && obj_ok(rx.obj) |=> rx_hit_valid)
    else $error("receive check not answered");

  hit_hold_a: assert property (
    !(rx.check && obj_ok(rx.obj)) |=> $stable(rx_hit))
    else $error("filter result changed without a check");

  ide_gate_a: assert property (
    rx.check && obj_ok(rx.obj) && sel_mask[IDE_MASK_BIT] &&
      rx.ide != rx.tag_ide |=> !rx_hit)
    else $error("extension bit mismatch accepted with mask set");

  // standard frames look at identifier bits 10..0 only
  std_id_miss_a: assert property (
    rx.check && obj_ok(rx.obj) && !rx.ext_layout &&
      (sel_mask[31:21] & (rx.id[10:0] ^ rx.tag_id[10:0])) != 11'h0 |=>
      !rx_hit)
    else $error("masked standard identifier mismatch accepted");

  ext_id_miss_a: assert property (
    rx.check && obj_ok(rx.obj) && rx.ext_layout &&
      (sel_mask[31:3] & (rx.id ^ rx.tag_id)) != 29'h0 |=> !rx_hit)
    else $error("masked extended identifier mismatch accepted");

endmodule : can_mask_window
`default_nettype wire

// ---- verification/can_mask_window_tb_top.sv ----
// self-checking bench for the message object masks and data window
// assumes the design package compiled first; drives all ports directly
`timescale 1ns/1ps
`default_nettype none
module can_mask_window_tb_top;
  import can_win_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  sfr_req_t sfr = '0;
  page_sel_t page = '0;
  rx_frame_t rx = '0;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic [2:0] data_index;
  logic rx_hit;
  logic rx_hit_valid;
  int errors = 0;
  int n_compared = 0;
  int seed = 70;
  int cycles = 0;
  logic [31:0] mask_m [OBJ_N];
  logic [7:0] dbuf [DATA_BYTES];
  ////////////////////////////////////////////////////////////////////////
  can_mask_window can_mask_window_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .sfr(sfr), .page(page), .rx(rx), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .data_index(data_index), .rx_hit(rx_hit),
    .rx_hit_valid(rx_hit_valid));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // generous ceiling, the run needs about 830 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    sfr <= '0;
  endtask : wr
  // read; answer awaited for at most four edges
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e,
                          input logic eo);
    logic ok;
    logic [7:0] got;
    ok = 1'b0;
    got = 8'h00;
    @(posedge clk_sys);
    sfr <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    sfr <= '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (sfr_rvalid === 1'b1) begin
        ok = 1'b1;
        got = sfr_rdata;
      end else @(posedge clk_sys);
    end
    check(ok, eo);
    if (eo) check(got, e);
  endtask : rd_check
  task automatic set_page(input logic [3:0] o, input logic x, input logic ai);
    @(posedge clk_sys);
    page <= '{o, 3'h0, 1'b0, x, ai};
  endtask : set_page
  task automatic load_idx(input logic [2:0] i);
    @(posedge clk_sys);
    page.idx <= i;
    page.load <= 1'b1;
    @(posedge clk_sys);
    page.load <= 1'b0;
  endtask : load_idx
  function automatic logic [7:0] mask_rd(logic [31:0] m, int k, logic x);
    logic [7:0] b;
    b = m[31-8*k -: 8];
    case (k)
      1: return x ? b : b & STD_KEEP2;
      2: return x ? b : b & STD_KEEP3;
      3: return b & (x ? EXT_KEEP4 : STD_KEEP4);
      default: return b;
    endcase
  endfunction : mask_rd
  function automatic logic hit_exp(logic [31:0] m, rx_frame_t f);
    logic [28:0] idm;
    idm = f.ext_layout ? {m[31:8], m[7:3]} : {18'h0, m[31:21]};
    return (((f.id ^ f.tag_id) & idm) == 29'h0)
      && !(m[2] && (f.rtr != f.tag_rtr)) && !(m[0] && (f.ide != f.tag_ide));
  endfunction : hit_exp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] m;
    rx_frame_t f;
    int o;
    logic [7:0] eb;
    logic hb;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (o = 0; o < OBJ_N; o++) begin
      set_page(o[3:0], o[0], 1'b0);
      m = $random(seed);
      if (o < 2) m = o[0] ? 32'hffff_fffd : 32'h0;
      m = m & (o[0] ? 32'hffff_fffd : 32'hffe0_0005);
      mask_m[o] = m;
      for (int k = 0; k < 4; k++) wr(ADDR_MASK1 + k[7:0], m[31-8*k -: 8]);
    end
    for (o = 0; o < OBJ_N; o++) begin
      set_page(o[3:0], o[0], 1'b0);
      for (int k = 0; k < 4; k++) begin
        eb = mask_rd(mask_m[o], k, o[0]);
        rd_check(ADDR_MASK1 + k[7:0], eb, 1'b1);
      end
    end
    // back to back: write then read at once, twice, then two more reads in a row
    set_page(4'h2, 1'b0, 1'b0);
    mask_m[2][31:24] = 8'h5a;
    @(posedge clk_sys);
    sfr <= '{1'b1, 1'b0, ADDR_MASK1, 8'h5a};
    @(posedge clk_sys);
    sfr <= '{1'b0, 1'b1, ADDR_MASK1, 8'h00};
    @(posedge clk_sys);
    sfr <= '{1'b1, 1'b0, ADDR_MSG, 8'hc3};
    @(posedge clk_sys);
    sfr <= '{1'b0, 1'b1, ADDR_MSG, 8'h00};
    #1;
    check({sfr_rvalid, sfr_rdata}, {1'b1, 8'h5a});
    @(posedge clk_sys);
    sfr <= '{1'b0, 1'b1, ADDR_MASK2, 8'h00};
    @(posedge clk_sys);
    sfr <= '{1'b0, 1'b1, ADDR_MASK4, 8'h00};
    #1;
    check({sfr_rvalid, sfr_rdata}, {1'b1, 8'hc3});
    @(posedge clk_sys);
    sfr <= '0;
    #1;
    eb = mask_rd(mask_m[2], 1, 1'b0);
    check({sfr_rvalid, sfr_rdata}, {1'b1, eb});
    @(posedge clk_sys);
    #1;
    eb = mask_rd(mask_m[2], 3, 1'b0);
    check({sfr_rvalid, sfr_rdata}, {1'b1, eb});
    // ten writes from index 6 cross the 7 to 0 wrap
    set_page(4'h5, 1'b0, 1'b1);
    load_idx(3'h6);
    for (int i = 0; i < 10; i++) begin
      m = $random(seed);
      dbuf[(6 + i) % 8] = m[7:0];
      wr(ADDR_MSG, m[7:0]);
      #1;
      check(data_index, (7 + i) % 8);
    end
    set_page(4'h6, 1'b0, 1'b1);
    load_idx(3'h0);
    wr(ADDR_MSG, ~dbuf[0]);
    set_page(4'h5, 1'b0, 1'b1);
    load_idx(3'h6);
    for (int i = 0; i < 8; i++) begin
      rd_check(ADDR_MSG, dbuf[(6 + i) % 8], 1'b1);
    end
    set_page(4'h5, 1'b0, 1'b0);
    load_idx(3'h3);
    repeat (2) rd_check(ADDR_MSG, dbuf[3], 1'b1);
    check(data_index, 3'h3);
    rd_check(8'hb0, 8'h00, 1'b0);
    set_page(4'hf, 1'b0, 1'b0);
    rd_check(ADDR_MSG, 8'h00, 1'b0);
    for (int n = 0; n < 200; n++) begin
      o = $unsigned($random(seed)) % OBJ_N;
      f = '0;
      f.check = 1'b1;
      f.obj = o[3:0];
      f.ext_layout = o[0];
      f.id = 29'($random(seed));
      f.tag_id = f.id;
      if (n[0]) f.tag_id = f.id ^ 29'($random(seed) & $random(seed));
      {f.rtr, f.ide, f.tag_rtr, f.tag_ide} = 4'($random(seed));
      @(posedge clk_sys);
      rx <= f;
      @(posedge clk_sys);
      rx.check <= 1'b0;
      #1;
      hb = hit_exp(mask_m[o], f);
      check({rx_hit_valid, rx_hit}, {1'b1, hb});
    end
    give_verdict();
  end
endmodule : can_mask_window_tb_top
`default_nettype wire
